// ---- hw/irc_cfg.svh ----
// Purpose: Constants of the infrared carrier generator
// Assumes: APB byte addresses, 32-bit data, one register per word
// Notes  : Offsets, field positions, reset values and counts
`ifndef IRC_CFG_SVH
`define IRC_CFG_SVH

// =====================================================================
// Register offsets
`define IRC_CTRL_ADDR   12'h000
`define IRC_LOW_ADDR    12'h004
`define IRC_HIGH_ADDR   12'h008
`define IRC_STAT_ADDR   12'h00C
`define IRC_ISTAT_ADDR  12'h010
`define IRC_IMASK_ADDR  12'h014

// =====================================================================
// Field positions
`define IRC_CTRL_EN_BIT    0
`define IRC_CTRL_RMC_BIT   1
`define IRC_CTRL_GBUF_BIT  2
`define IRC_STAT_GACT_BIT  0
`define IRC_STAT_CAR_BIT   1
`define IRC_STAT_ITV_BIT   2
`define IRC_STAT_PEND_BIT  3
`define IRC_STAT_CNT_LSB   8
`define IRC_IRQ_MATCH_BIT  0

// =====================================================================
// Reset values and timing
`define IRC_CMP_RST        8'h01
`define IRC_AGE_MIN        2'h3

`endif

// ---- hw/irc_pkg.sv ----
// Purpose: Types of the infrared carrier generator
// Assumes: Used by package-qualified names only
// Notes  : Compare selection of the carrier counter
package irc_pkg;

  // ===================================================================
  // Compare selection
  typedef enum logic {IRC_SEL_LOW, IRC_SEL_HIGH} irc_sel_t;

endpackage

// ---- hw/irc_sync.sv ----
// Purpose: Three-stage synchroniser with filtered level and rise pulse
// Assumes: Inputs come from another clock domain
// Notes  : A change is taken once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module irc_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Asynchronous inputs
  input  wire logic [W-1:0] async_in,
  // Filtered outputs
  output var  logic [W-1:0] level_q,
  output var  logic [W-1:0] rise_q
);

  // ===================================================================
  // One synchroniser per bit
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else
        begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // Filtered level and single-cycle rise pulse
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          level_q[i] <= 1'b0;
          rise_q[i]  <= 1'b0;
        end
        else
        begin
          if (s2_q == s3_q)
          begin
            level_q[i] <= s3_q;
          end
          rise_q[i] <= (s2_q == s3_q) && s3_q && !level_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- hw/irc_gen.sv ----
// Purpose: Infrared carrier generator with gated output and APB registers
// Assumes: Count clock is sys_clk; interval timer lives outside
// Notes  : Zero-wait APB slave, one level interrupt for compare matches
`timescale 1ns/10ps
`default_nettype none
`include "irc_cfg.svh"

module irc_gen #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Interval timer
  input  wire logic        interval_event_in,
  input  wire logic        interval_timer_enable,
  // Carrier and events
  output var  logic        carrier_out_pin,
  output var  logic        compare_match_event,
  output var  logic        interval_event_synced,
  output var  logic        irq
);

  // ===================================================================
  // Declarations
  logic             carrier_timer_enable;
  logic             remote_output_enable;
  logic             gate_buffer_bit;
  logic             gate_active_bit;
  logic [CNT_W-1:0] low_width_compare;
  logic [CNT_W-1:0] high_act_q;
  logic [CNT_W-1:0] high_pend_q;
  logic             pend_q;
  logic [1:0]       age_q;
  logic [CNT_W-1:0] cnt_q;
  irc_pkg::irc_sel_t sel_q;
  logic             carrier_q;
  logic             carrier_d;
  logic             pass_q;
  logic             pass_d;
  logic             out_d;
  logic             match_q;
  logic             load_q;
  logic             istat_q;
  logic             imask_q;
  logic             irq_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [1:0]       sync_level;
  logic [1:0]       sync_rise;
  logic             itv_en;
  logic             ev_sync;
  logic [CNT_W-1:0] cmp_val;
  logic             hit_cmp;
  logic             setup;
  logic             wr_en;
  logic             mapped;
  logic             install;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite && pstrb[0];

  // ===================================================================
  // Interval event and enable synchroniser
  irc_sync #(
    .W (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({interval_timer_enable, interval_event_in}),
    .level_q  (sync_level),
    .rise_q   (sync_rise)
  );

  assign itv_en  = sync_level[1];
  assign ev_sync = sync_rise[0];

  // ===================================================================
  // Address decode
  always_comb
  begin
    case (paddr)
      `IRC_CTRL_ADDR,
      `IRC_LOW_ADDR,
      `IRC_HIGH_ADDR,
      `IRC_STAT_ADDR,
      `IRC_ISTAT_ADDR,
      `IRC_IMASK_ADDR: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  end

  // ===================================================================
  // APB handshake and read data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= 32'h0000_0000;
      if (setup && !pwrite)
      begin
        case (paddr)
          `IRC_CTRL_ADDR:
          begin
            prdata_q[`IRC_CTRL_EN_BIT]   <= carrier_timer_enable;
            prdata_q[`IRC_CTRL_RMC_BIT]  <= remote_output_enable;
            prdata_q[`IRC_CTRL_GBUF_BIT] <= gate_buffer_bit;
          end
          `IRC_LOW_ADDR:   prdata_q[CNT_W-1:0] <= low_width_compare;
          `IRC_HIGH_ADDR:  prdata_q[CNT_W-1:0] <= high_act_q;
          `IRC_STAT_ADDR:
          begin
            prdata_q[`IRC_STAT_GACT_BIT] <= gate_active_bit;
            prdata_q[`IRC_STAT_CAR_BIT]  <= carrier_q;
            prdata_q[`IRC_STAT_ITV_BIT]  <= itv_en;
            prdata_q[`IRC_STAT_PEND_BIT] <= pend_q;
            prdata_q[`IRC_STAT_CNT_LSB +: CNT_W] <= cnt_q;
          end
          `IRC_ISTAT_ADDR: prdata_q[`IRC_IRQ_MATCH_BIT] <= istat_q;
          `IRC_IMASK_ADDR: prdata_q[`IRC_IRQ_MATCH_BIT] <= imask_q;
          default:         prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ===================================================================
  // Control register and low-width compare
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrier_timer_enable <= 1'b0;
      remote_output_enable <= 1'b0;
      gate_buffer_bit      <= 1'b0;
      low_width_compare    <= `IRC_CMP_RST;
      imask_q              <= 1'b0;
    end
    else if (wr_en)
    begin
      if (paddr == `IRC_CTRL_ADDR)
      begin
        carrier_timer_enable <= pwdata[`IRC_CTRL_EN_BIT];
        remote_output_enable <= pwdata[`IRC_CTRL_RMC_BIT];
        gate_buffer_bit      <= pwdata[`IRC_CTRL_GBUF_BIT];
      end
      if (paddr == `IRC_LOW_ADDR)
      begin
        low_width_compare <= pwdata[CNT_W-1:0];
      end
      if (paddr == `IRC_IMASK_ADDR)
      begin
        imask_q <= pwdata[`IRC_IRQ_MATCH_BIT];
      end
    end
  end

  // ===================================================================
  // Compare selection and next carrier level
  always_comb
  begin
    cmp_val   = (sel_q == irc_pkg::IRC_SEL_HIGH) ? high_act_q
                                                 : low_width_compare;
    hit_cmp   = carrier_timer_enable && (cnt_q == cmp_val);
    carrier_d = carrier_timer_enable && (carrier_q ^ hit_cmp);
    install   = hit_cmp && (sel_q == irc_pkg::IRC_SEL_HIGH) && pend_q
                && (age_q >= `IRC_AGE_MIN);
  end

  // ===================================================================
  // Carrier counter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q     <= '0;
      sel_q     <= irc_pkg::IRC_SEL_LOW;
      carrier_q <= 1'b0;
      match_q   <= 1'b0;
    end
    else
    begin
      carrier_q <= carrier_d;
      match_q   <= hit_cmp;
      if (!carrier_timer_enable)
      begin
        cnt_q <= '0;
        sel_q <= irc_pkg::IRC_SEL_LOW;
      end
      else if (hit_cmp)
      begin
        cnt_q <= '0;
        case (sel_q)
          irc_pkg::IRC_SEL_LOW:  sel_q <= irc_pkg::IRC_SEL_HIGH;
          irc_pkg::IRC_SEL_HIGH: sel_q <= irc_pkg::IRC_SEL_LOW;
          default:               sel_q <= irc_pkg::IRC_SEL_LOW;
        endcase
      end
      else
      begin
        cnt_q <= CNT_W'(cnt_q + 1'b1);
      end
    end
  end

  // ===================================================================
  // High-width compare with deferred install
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_act_q  <= `IRC_CMP_RST;
      high_pend_q <= `IRC_CMP_RST;
      pend_q      <= 1'b0;
      age_q       <= 2'h0;
    end
    else if (wr_en && paddr == `IRC_HIGH_ADDR)
    begin
      high_pend_q <= pwdata[CNT_W-1:0];
      age_q       <= 2'h0;
      if (!carrier_timer_enable)
      begin
        high_act_q <= pwdata[CNT_W-1:0];
        pend_q     <= 1'b0;
      end
      else
      begin
        pend_q <= 1'b1;
      end
    end
    else if (!carrier_timer_enable)
    begin
      pend_q <= 1'b0;
    end
    else if (install)
    begin
      high_act_q <= high_pend_q;
      pend_q     <= 1'b0;
    end
    else if (pend_q && age_q < `IRC_AGE_MIN)
    begin
      age_q <= 2'(age_q + 1'b1);
    end
  end

  // ===================================================================
  // Gate transfer from buffer to active bit
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_q          <= 1'b0;
      gate_active_bit <= 1'b0;
    end
    else
    begin
      load_q <= ev_sync;
      if (load_q)
      begin
        gate_active_bit <= gate_buffer_bit;
      end
    end
  end

  // ===================================================================
  // Output gating
  always_comb
  begin
    if (!carrier_timer_enable)
    begin
      pass_d = 1'b0;
    end
    else if (gate_active_bit && carrier_d && !carrier_q)
    begin
      pass_d = 1'b1;
    end
    else if (!gate_active_bit && !carrier_d)
    begin
      pass_d = 1'b0;
    end
    else
    begin
      pass_d = pass_q;
    end
    out_d = remote_output_enable ? (pass_d && carrier_d)
                                 : gate_active_bit;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pass_q          <= 1'b0;
      carrier_out_pin <= 1'b0;
    end
    else
    begin
      pass_q          <= pass_d;
      carrier_out_pin <= out_d;
    end
  end

  // ===================================================================
  // Interrupt status, mask and output
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      istat_q <= 1'b0;
      irq_q   <= 1'b0;
    end
    else
    begin
      if (match_q)
      begin
        istat_q <= 1'b1;
      end
      else if (wr_en && paddr == `IRC_ISTAT_ADDR
               && pwdata[`IRC_IRQ_MATCH_BIT])
      begin
        istat_q <= 1'b0;
      end
      irq_q <= istat_q && imask_q;
    end
  end

  // ===================================================================
  // Port drivers
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign compare_match_event   = match_q;
  assign interval_event_synced = ev_sync;
  assign irq                   = irq_q;

  // ===================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_hold_stopped: assert property (
    !carrier_timer_enable && !itv_en |=> cnt_q == '0 && !carrier_q)
    else $error("counter moved while stopped");

  a_start_default: assert property (
    $rose(carrier_timer_enable) |-> !carrier_q ##1 !carrier_q)
    else $error("carrier left default at start");

  a_low_match: assert property (
    carrier_timer_enable && sel_q == irc_pkg::IRC_SEL_LOW
    && cnt_q == low_width_compare
    |=> match_q && carrier_q && cnt_q == '0
        && sel_q == irc_pkg::IRC_SEL_HIGH)
    else $error("low match handling wrong");

  a_high_match: assert property (
    carrier_timer_enable && sel_q == irc_pkg::IRC_SEL_HIGH
    && cnt_q == high_act_q
    |=> match_q && !carrier_q && cnt_q == '0
        && sel_q == irc_pkg::IRC_SEL_LOW)
    else $error("high match handling wrong");

  a_sync_pulse: assert property (
    ev_sync |=> !ev_sync)
    else $error("synced event wider than one clock");

  a_gate_load: assert property (
    ev_sync |=> ##1 gate_active_bit == $past(gate_buffer_bit))
    else $error("gate not loaded on second clock");

  a_out_low: assert property (
    !$past(gate_active_bit) && !carrier_q |-> !carrier_out_pin)
    else $error("output not low with gate off");

  a_no_midphase: assert property (
    remote_output_enable && $past(remote_output_enable)
    && $rose(carrier_out_pin) |-> $rose(carrier_q))
    else $error("carrier passed mid-phase");

  a_high_kept: assert property (
    remote_output_enable && carrier_out_pin && carrier_q
    |=> !remote_output_enable || !carrier_q || carrier_out_pin)
    else $error("high phase cut short");

  a_early_kept: assert property (
    hit_cmp && sel_q == irc_pkg::IRC_SEL_HIGH && pend_q
    && age_q < `IRC_AGE_MIN && !wr_en
    |=> high_act_q == $past(high_act_q))
    else $error("early install of high compare");

  a_install_new: assert property (
    install && !wr_en |=> high_act_q == $past(high_pend_q)
    && !pend_q)
    else $error("high compare not installed");

  c_full_period: cover property (
    match_q ##[1:300] match_q ##[1:300] match_q);
  c_gate_on: cover property ($rose(gate_active_bit));
  c_install: cover property (install);
  c_early_match: cover property (
    hit_cmp && sel_q == irc_pkg::IRC_SEL_HIGH && pend_q
    && age_q < `IRC_AGE_MIN);

endmodule

`default_nettype wire

// ---- test/irc_itv_model.sv ----
// Purpose: Interval timer model that raises gating events
// Assumes: Event spacing well above six count clocks
// Notes  : Event level stands five clocks so the filter takes it
`timescale 1ns/10ps
`default_nettype none

module irc_itv_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Bench control
  input  wire logic       run,
  input  wire logic [7:0] gap,
  // Interval timer outputs
  output var  logic       interval_event_in,
  output var  logic       interval_timer_enable
);
  logic [7:0] cnt_q;

  // ==========
  // Interval count, event level and enable
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q                 <= 8'h00;
      interval_event_in     <= 1'b0;
      interval_timer_enable <= 1'b0;
    end
    else
    begin
      cnt_q                 <= (!run || cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
      interval_event_in     <= run && (cnt_q + 8'h04 >= gap);
      interval_timer_enable <= run;
    end
  end
endmodule

`default_nettype wire

// ---- test/test_ir_carrier_generator.sv ----
// Purpose: Self-checking bench of the infrared carrier generator
// Assumes: One clock, APB register access, interval timer model
// Notes  : Gaps between match pulses are compared with the compare values plus one
`timescale 1ns/10ps
`default_nettype none
`include "irc_cfg.svh"

module test_ir_carrier_generator;
  // ==========
  // Signals
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        interval_event_in, interval_timer_enable, carrier_out_pin;
  logic        compare_match_event, interval_event_synced, irq;
  logic        run, pin_chk, ev_prev, se;
  logic [7:0]  gap;
  int          errors, comparisons, seed, n, hi, run_len, gcnt, c;
  int          itv_in, itv_out, gaps[$];
  localparam logic [31:0] c_en = 32'h1 << `IRC_CTRL_EN_BIT;
  localparam logic [31:0] c_rmc = 32'h1 << `IRC_CTRL_RMC_BIT;
  localparam logic [31:0] c_gb = 32'h1 << `IRC_CTRL_GBUF_BIT;

  irc_gen dut (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .interval_event_in, .interval_timer_enable,
    .carrier_out_pin, .compare_match_event, .interval_event_synced, .irq
  );
  irc_itv_model itv (
    .sys_clk, .rst_n, .run, .gap, .interval_event_in, .interval_timer_enable
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========
  // Monitor: match gaps, pin high runs, interval events
  always @(posedge sys_clk)
  begin
    gcnt++;
    if (compare_match_event === 1'b1)
    begin
      gaps.push_back(gcnt);
      gcnt = 0;
    end
    if (pin_chk && carrier_out_pin === 1'b1)
      run_len++;
    else if (run_len > 0)
    begin
      check(run_len, hi + 1);
      run_len = 0;
    end
    if (interval_event_in && !ev_prev)
      itv_in++;
    ev_prev = interval_event_in;
    if (interval_event_synced === 1'b1)
      itv_out++;
  end

  // ==========
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      check(k, 0);
      final_report;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    bound(k, 50);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] mask,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hF);
    check(rd & mask, exp);
  endtask

  task automatic wait_ev(input bit sync_ev);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      c++;
    end
    while ((sync_ev ? interval_event_synced : compare_match_event) !== 1'b1
           && c < 900);
    bound(c, 900);
  endtask

  task automatic chk_seq(input int exp[$]);
    int k;
    k = 0;
    while (gaps.size() <= exp.size() && k < 2000)
    begin
      @(posedge sys_clk);
      k++;
    end
    bound(k, 2000);
    foreach (exp[i])
      check(gaps[i + 1], exp[i]);
  endtask

  task automatic pin_is(input logic v, input int cyc);
    repeat (cyc)
    begin
      @(posedge sys_clk);
      check(carrier_out_pin, v);
    end
  endtask

  // ==========
  // Main sequence
  initial
  begin
    seed = 56;
    rst_n = 1'b0;
    {psel, penable, pwrite, run, pin_chk} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    gap = 8'h28;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(`IRC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0);
    rdc(`IRC_LOW_ADDR, 32'hFFFFFFFF, `IRC_CMP_RST);
    rdc(`IRC_HIGH_ADDR, 32'hFFFFFFFF, `IRC_CMP_RST);
    rdc(12'h018, 32'hFFFFFFFF, 32'h0);
    check(se, 1'b1);
    wr(`IRC_STAT_ADDR, 32'hFFFFFFFF);
    apb(1'b1, `IRC_CTRL_ADDR, c_en, 4'hE);
    repeat (20) @(posedge sys_clk);
    rdc(`IRC_STAT_ADDR, 32'hFFFFFFFF, 32'h0);
    rdc(`IRC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0);
    $display("Test registers done");
    n = 2 + $unsigned($random(seed)) % 6;
    hi = 2 + $unsigned($random(seed)) % 6;
    wr(`IRC_LOW_ADDR, n);
    wr(`IRC_HIGH_ADDR, hi);
    rdc(`IRC_HIGH_ADDR, 32'hFF, hi);
    wr(`IRC_IMASK_ADDR, 32'h1);
    wr(`IRC_CTRL_ADDR, c_en);
    gaps.delete();
    wait_ev(1'b0);
    check(c, n + 2);
    chk_seq('{hi + 1, n + 1, hi + 1, n + 1});
    check(irq, 1'b1);
    rdc(`IRC_ISTAT_ADDR, 32'h1, 32'h1);
    wr(`IRC_CTRL_ADDR, 32'h0);
    rdc(`IRC_STAT_ADDR, 32'h0000FF02, 32'h0);
    wr(`IRC_ISTAT_ADDR, 32'h1);
    rdc(`IRC_ISTAT_ADDR, 32'h1, 32'h0);
    check(irq, 1'b0);
    wr(`IRC_IMASK_ADDR, 32'h0);
    wr(`IRC_CTRL_ADDR, c_en);
    wait_ev(1'b0);
    check(c, n + 2);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0);
    wr(`IRC_CTRL_ADDR, 32'h0);
    wr(`IRC_ISTAT_ADDR, 32'h1);
    $display("Test carrier and interrupt done");
    wr(`IRC_LOW_ADDR, 32'h3);
    wr(`IRC_HIGH_ADDR, 32'h8);
    wr(`IRC_CTRL_ADDR, c_en);
    gaps.delete();
    wait_ev(1'b0);
    wr(`IRC_HIGH_ADDR, 32'h6);
    wait_ev(1'b0);
    wait_ev(1'b0);
    repeat (2) @(posedge sys_clk);
    wr(`IRC_HIGH_ADDR, 32'hA);
    rdc(`IRC_HIGH_ADDR, 32'hFF, 32'h6);
    rdc(`IRC_STAT_ADDR, 32'h8, 32'h8);
    chk_seq('{9, 4, 7, 4, 7, 4, 11});
    rdc(`IRC_STAT_ADDR, 32'h8, 32'h0);
    wr(`IRC_CTRL_ADDR, 32'h0);
    $display("Test compare update done");
    n = 2 + $unsigned($random(seed)) % 6;
    hi = 2 + $unsigned($random(seed)) % 6;
    wr(`IRC_LOW_ADDR, n);
    wr(`IRC_HIGH_ADDR, hi);
    wr(`IRC_CTRL_ADDR, c_en | c_rmc | c_gb);
    pin_chk = 1'b1;
    run <= 1'b1;
    wait_ev(1'b1);
    repeat (4) @(posedge sys_clk);
    rdc(`IRC_STAT_ADDR, 32'h5, 32'h5);
    rdc(`IRC_CTRL_ADDR, 32'h7, c_en | c_rmc | c_gb);
    repeat (60) @(posedge sys_clk);
    wr(`IRC_CTRL_ADDR, c_en | c_rmc);
    wait_ev(1'b1);
    repeat (40) @(posedge sys_clk);
    pin_is(1'b0, 30);
    rdc(`IRC_STAT_ADDR, 32'h1, 32'h0);
    pin_chk = 1'b0;
    wr(`IRC_CTRL_ADDR, c_en | c_gb);
    wait_ev(1'b1);
    repeat (4) @(posedge sys_clk);
    pin_is(1'b1, 30);
    run <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check(itv_out, itv_in);
    rdc(`IRC_STAT_ADDR, 32'h4, 32'h0);
    $display("Test output gating done");
    final_report;
  end
endmodule

`default_nettype wire
